//--- design/tmwm_pkg.sv
// constants and types for the 8-bit waveform timer
package tmwm_pkg;
  // ----------------------------------------
  // counter extremes and unit step
  // ----------------------------------------
  localparam logic [7:0] TMWM_BOTTOM = 8'h00;
  localparam logic [7:0] TMWM_MAX = 8'hFF;
  localparam logic [7:0] TMWM_ONE = 8'h01;
  // ----------------------------------------
  // wave mode encodings
  // ----------------------------------------
  localparam logic [2:0] TMWM_MODE_NORMAL = 3'h0;
  localparam logic [2:0] TMWM_MODE_PC_FF = 3'h1;
  localparam logic [2:0] TMWM_MODE_CTC = 3'h2;
  localparam logic [2:0] TMWM_MODE_FAST_FF = 3'h3;
  localparam logic [2:0] TMWM_MODE_PC_A = 3'h5;
  localparam logic [2:0] TMWM_MODE_FAST_A = 3'h7;
  localparam int TMWM_MODE_BIT2 = 2;
  // ----------------------------------------
  // output action encodings
  // ----------------------------------------
  localparam logic [1:0] TMWM_ACT_OFF = 2'h0;
  localparam logic [1:0] TMWM_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMWM_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMWM_ACT_SET = 2'h3;
  typedef enum logic [1:0] {TMWM_KIND_NONPWM, TMWM_KIND_FAST, TMWM_KIND_PC} tmwm_kind_t;
endpackage

//--- design/tmwm_timer.sv
// 8-bit timer with clear-on-match, fast pwm and phase correct pwm waveforms
`timescale 1ns/1ps
module tmwm_timer
  import tmwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic timer_tick,
  input wire logic [2:0] wave_mode_sel,
  input wire logic [1:0] output_action_a,
  input wire logic [1:0] output_action_b,
  input wire logic [7:0] compare_a_wdata,
  input wire logic compare_a_we,
  input wire logic [7:0] compare_b_wdata,
  input wire logic compare_b_we,
  input wire logic [7:0] count_wdata,
  input wire logic count_we,
  input wire logic compare_a_flag_clr,
  input wire logic compare_b_flag_clr,
  input wire logic overflow_flag_clr,
  output logic [7:0] count_value,
  output logic [7:0] compare_a_value,
  output logic [7:0] compare_b_value,
  output logic compare_a_flag,
  output logic compare_b_flag,
  output logic overflow_flag,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_out_a_en,
  output logic wave_out_b_en
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic tmwm_kind_t tmwm_kind(input logic [2:0] m);
    tmwm_kind_t k;
    k = TMWM_KIND_NONPWM;
    if (m == TMWM_MODE_FAST_FF || m == TMWM_MODE_FAST_A) begin
      k = TMWM_KIND_FAST;
    end else if (m == TMWM_MODE_PC_FF || m == TMWM_MODE_PC_A) begin
      k = TMWM_KIND_PC;
    end
    return k;
  endfunction

  tmwm_kind_t kind;
  logic clear_on_match_mode;
  logic top_is_a;
  logic [7:0] top_value;
  logic count_down;
  logic [7:0] buf_a;
  logic [7:0] buf_b;
  logic block_match;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic [7:0] next_count;
  logic next_down;

  assign kind = tmwm_kind(wave_mode_sel);
  assign clear_on_match_mode = (wave_mode_sel == TMWM_MODE_CTC);
  assign top_is_a = wave_mode_sel[TMWM_MODE_BIT2] || clear_on_match_mode;
  assign top_value = top_is_a ? compare_a_value : TMWM_MAX;
  assign at_top = (count_value == top_value);
  assign at_bottom = (count_value == TMWM_BOTTOM);
  // a counter write masks comparison for one tick
  assign match_a = (count_value == compare_a_value) && !block_match;
  assign match_b = (count_value == compare_b_value) && !block_match;
  // pins are driven only while the action is off; direction itself is software's job
  assign wave_out_a_en = !(output_action_a != TMWM_ACT_OFF);
  assign wave_out_b_en = !(output_action_b != TMWM_ACT_OFF);

  // ----------------------------------------
  // compare buffers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_a <= TMWM_BOTTOM;
      buf_b <= TMWM_BOTTOM;
      compare_a_value <= TMWM_BOTTOM;
      compare_b_value <= TMWM_BOTTOM;
    end else begin
      if (compare_a_we) begin
        buf_a <= compare_a_wdata;
      end
      if (compare_b_we) begin
        buf_b <= compare_b_wdata;
      end
      if (kind == TMWM_KIND_NONPWM) begin
        // no double buffer: direct write lets a lower value miss the match
        if (compare_a_we) begin
          compare_a_value <= compare_a_wdata;
        end
        if (compare_b_we) begin
          compare_b_value <= compare_b_wdata;
        end
      end else if (timer_tick && at_top && (kind == TMWM_KIND_FAST || !count_down)) begin
        compare_a_value <= buf_a;
        compare_b_value <= buf_b;
      end
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_comb begin
    next_count = count_value;
    next_down = count_down;
    case (kind)
      TMWM_KIND_FAST: begin
        next_down = 1'b0;
        next_count = at_top ? TMWM_BOTTOM : count_value + TMWM_ONE;
      end
      TMWM_KIND_PC: begin
        if (at_top) begin
          next_down = 1'b1;
        end else if (at_bottom) begin
          next_down = 1'b0;
        end
        if (at_top) begin
          next_count = count_value - TMWM_ONE;
        end else if (at_bottom) begin
          next_count = count_value + TMWM_ONE;
        end else begin
          next_count = count_down ? count_value - TMWM_ONE : count_value + TMWM_ONE;
        end
      end
      default: begin
        next_down = 1'b0;
        if (clear_on_match_mode && match_a) begin
          next_count = TMWM_BOTTOM;
        end else begin
          next_count = count_value + TMWM_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_value <= TMWM_BOTTOM;
      count_down <= 1'b0;
    end else if (count_we) begin
      count_value <= count_wdata;
    end else if (timer_tick) begin
      count_value <= next_count;
      count_down <= next_down;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      block_match <= 1'b0;
    end else if (count_we) begin
      block_match <= 1'b1;
    end else if (timer_tick) begin
      block_match <= 1'b0;
    end
  end

  // ----------------------------------------
  // flags: set wins over clear
  // ----------------------------------------
  logic set_a;
  logic set_b;
  logic set_ov;
  assign set_a = timer_tick && match_a;
  assign set_b = timer_tick && match_b;
  always_comb begin
    case (kind)
      TMWM_KIND_FAST: set_ov = timer_tick && at_top;
      TMWM_KIND_PC: set_ov = timer_tick && at_bottom && count_down;
      // a match at max also passes max to zero, so it must not hide the overflow
      default: set_ov = timer_tick && (count_value == TMWM_MAX);
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      compare_a_flag <= 1'b0;
      compare_b_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      compare_a_flag <= set_a || (compare_a_flag && !compare_a_flag_clr);
      compare_b_flag <= set_b || (compare_b_flag && !compare_b_flag_clr);
      overflow_flag <= set_ov || (overflow_flag && !overflow_flag_clr);
    end
  end

  // ----------------------------------------
  // waveform outputs
  // ----------------------------------------
  // one function serves both channels; only A may toggle in pwm
  function automatic logic tmwm_wave(input logic cur, input logic [1:0] act, input logic m, input logic is_a,
                                     input logic [7:0] cmp);
    logic v;
    v = cur;
    case (kind)
      TMWM_KIND_FAST: begin
        if (act == TMWM_ACT_TOGGLE) begin
          if (is_a && wave_mode_sel[TMWM_MODE_BIT2] && m) begin
            v = !cur;
          end
        end else if (act[1]) begin
          // match at top is ignored; bottom action then wins, giving the constant level
          if (at_top) begin
            v = !act[0];
          end else if (m) begin
            v = act[0];
          end
        end
      end
      TMWM_KIND_PC: begin
        if (act == TMWM_ACT_TOGGLE) begin
          if (is_a && wave_mode_sel[TMWM_MODE_BIT2] && m) begin
            v = !cur;
          end
        end else if (act[1]) begin
          if (at_top && cmp == top_value) begin
            v = act[0] ^ 1'b1;
          end else if (at_bottom) begin
            // down-count level forced at bottom (up-count result if compare is bottom) keeps the pulse symmetric
            v = (cmp == TMWM_BOTTOM) ? act[0] : !act[0];
          end else if (m) begin
            v = count_down ? !act[0] : act[0];
          end
        end
      end
      default: begin
        if (m) begin
          case (act)
            TMWM_ACT_TOGGLE: v = !cur;
            TMWM_ACT_CLEAR: v = 1'b0;
            TMWM_ACT_SET: v = 1'b1;
            default: v = cur;
          endcase
        end
      end
    endcase
    return v;
  endfunction

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wave_out_a <= 1'b0;
    end else if (timer_tick) begin
      wave_out_a <= tmwm_wave(wave_out_a, output_action_a, match_a, 1'b1, compare_a_value);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wave_out_b <= 1'b0;
    end else if (timer_tick) begin
      wave_out_b <= tmwm_wave(wave_out_b, output_action_b, match_b, 1'b0, compare_b_value);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_ctc_clear;
    @(posedge clk_sys) disable iff (rst)
    (timer_tick && clear_on_match_mode && match_a && !count_we) |=> (count_value == TMWM_BOTTOM);
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc counter not cleared");

  property p_flag_a;
    @(posedge clk_sys) disable iff (rst)
    (timer_tick && match_a) |=> compare_a_flag;
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("compare a flag missing");

  property p_block;
    @(posedge clk_sys) disable iff (rst)
    (block_match && timer_tick && !compare_a_flag) |=> !compare_a_flag;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after write");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
    (!timer_tick && !count_we) |=> $stable(count_value);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");

  property p_fast_wrap;
    @(posedge clk_sys) disable iff (rst)
    (kind == TMWM_KIND_FAST && timer_tick && at_top && !count_we) |=> (count_value == TMWM_BOTTOM) && overflow_flag;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm wrap wrong");

  property p_pc_turn;
    @(posedge clk_sys) disable iff (rst)
    (kind == TMWM_KIND_PC && timer_tick && at_top && !at_bottom && !count_we) |=> count_down;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("phase correct no reversal");

  property p_pc_ov;
    @(posedge clk_sys) disable iff (rst)
    (kind == TMWM_KIND_PC && timer_tick && at_bottom && count_down) |=> overflow_flag;
  endproperty
  a_pc_ov: assert property (p_pc_ov) else $error("phase correct overflow missing");

  property p_ctc_toggle;
    @(posedge clk_sys) disable iff (rst)
    (clear_on_match_mode && timer_tick && match_a && output_action_a == TMWM_ACT_TOGGLE) |=> (wave_out_a != $past(wave_out_a));
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle) else $error("ctc toggle missing");

  property p_b_no_toggle;
    @(posedge clk_sys) disable iff (rst)
    (kind != TMWM_KIND_NONPWM && output_action_b == TMWM_ACT_TOGGLE && timer_tick) |=> $stable(wave_out_b);
  endproperty
  a_b_no_toggle: assert property (p_b_no_toggle) else $error("channel b toggled in pwm");

  c_ctc: cover property (@(posedge clk_sys) disable iff (rst) clear_on_match_mode && set_a);
  c_fast: cover property (@(posedge clk_sys) disable iff (rst) kind == TMWM_KIND_FAST && set_ov);
  c_pc: cover property (@(posedge clk_sys) disable iff (rst) kind == TMWM_KIND_PC && set_ov);
endmodule

//--- verification/tb_top.sv
// self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
module tb_top
  import tmwm_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic timer_tick = 1'b0;
  logic [2:0] wave_mode_sel = 3'h0;
  logic [1:0] output_action_a = 2'h0;
  logic [1:0] output_action_b = 2'h0;
  logic [7:0] compare_a_wdata = 8'h00;
  logic compare_a_we = 1'b0;
  logic [7:0] compare_b_wdata = 8'h00;
  logic compare_b_we = 1'b0;
  logic [7:0] count_wdata = 8'h00;
  logic count_we = 1'b0;
  logic clr = 1'b0;
  logic [7:0] count_value, compare_a_value, compare_b_value;
  logic compare_a_flag, compare_b_flag, overflow_flag;
  logic wave_out_a, wave_out_b, wave_out_a_en, wave_out_b_en;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  logic a0, b0;
  logic [7:0] c;
  always #12.5 clk_sys = ~clk_sys;
  tmwm_timer u_dut (.clk_sys(clk_sys), .rst(rst), .timer_tick(timer_tick), .wave_mode_sel(wave_mode_sel),
    .output_action_a(output_action_a), .output_action_b(output_action_b), .compare_a_wdata(compare_a_wdata),
    .compare_a_we(compare_a_we), .compare_b_wdata(compare_b_wdata), .compare_b_we(compare_b_we),
    .count_wdata(count_wdata), .count_we(count_we), .compare_a_flag_clr(clr), .compare_b_flag_clr(clr),
    .overflow_flag_clr(clr), .count_value(count_value), .compare_a_value(compare_a_value),
    .compare_b_value(compare_b_value), .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag),
    .overflow_flag(overflow_flag), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .wave_out_a_en(wave_out_a_en), .wave_out_b_en(wave_out_b_en));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_cnt(input logic [7:0] v);
    int i;
    i = 0;
    do begin
      cyc();
      i++;
    end while (count_value !== v && i < 2000);
    chk("count_value", v, count_value);
  endtask
  // ticks from one arrival at zero to the next
  task automatic measure(output int p);
    wait_cnt(8'h00);
    p = 0;
    do begin
      cyc();
      p++;
    end while (count_value !== 8'h00 && p < 700);
  endtask
  task automatic hi_count(input int len, output int na);
    na = 0;
    repeat (len) begin
      cyc();
      na += int'(wave_out_a === 1'b1);
    end
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    timer_tick <= 1'b0;
    wave_mode_sel <= TMWM_MODE_NORMAL;
    output_action_a <= TMWM_ACT_OFF;
    output_action_b <= TMWM_ACT_OFF;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  // compares are loaded in normal mode, where writes land at once
  task automatic setup(input logic [2:0] m, input logic [1:0] aa, ab, input logic [7:0] ca, cb);
    @(posedge clk_sys);
    compare_a_wdata <= ca;
    compare_b_wdata <= cb;
    compare_a_we <= 1'b1;
    compare_b_we <= 1'b1;
    @(posedge clk_sys);
    compare_a_we <= 1'b0;
    compare_b_we <= 1'b0;
    wave_mode_sel <= m;
    output_action_a <= aa;
    output_action_b <= ab;
    timer_tick <= 1'b1;
  endtask
  task automatic wr_a(input logic [7:0] v, input logic [7:0] exp);
    @(posedge clk_sys);
    compare_a_wdata <= v;
    compare_a_we <= 1'b1;
    @(posedge clk_sys);
    compare_a_we <= 1'b0;
    #1;
    chk("compare_a_value", exp, compare_a_value);
  endtask
  task automatic clr_flags();
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    cyc();
    chk("count_value", 8'h00, count_value);
    chk("wave_out_a_en", 1'b1, wave_out_a_en);
    chk("wave_out_b_en", 1'b1, wave_out_b_en);
    setup(TMWM_MODE_CTC, TMWM_ACT_TOGGLE, TMWM_ACT_CLEAR, 8'h03, 8'h02);
    wait_cnt(8'h03);
    chk("compare_b_flag", 1'b1, compare_b_flag);
    chk("compare_b_value", 8'h02, compare_b_value);
    cyc();
    chk("count_value", 8'h00, count_value);
    chk("compare_a_flag", 1'b1, compare_a_flag);
    chk("wave_out_a", 1'b1, wave_out_a);
    chk("wave_out_a_en", 1'b0, wave_out_a_en);
    chk("wave_out_b_en", 1'b0, wave_out_b_en);
    measure(n);
    chk("ctc period", 16'd4, n[15:0]);
    wr_a(8'h20, 8'h20);
    wait_cnt(8'h10);
    wr_a(8'h08, 8'h08);
    clr_flags();
    wait_cnt(8'hFF);
    chk("compare_a_flag", 1'b0, compare_a_flag);
    cyc();
    chk("overflow_flag", 1'b1, overflow_flag);
    wait_cnt(8'h08);
    cyc();
    chk("count_value", 8'h00, count_value);
    clr_flags();
    @(posedge clk_sys);
    count_wdata <= 8'h08;
    count_we <= 1'b1;
    @(posedge clk_sys);
    count_we <= 1'b0;
    cyc();
    chk("count_value", 8'h09, count_value);
    chk("compare_a_flag", 1'b0, compare_a_flag);
    timer_tick <= 1'b0;
    repeat (2) cyc();
    c = count_value;
    repeat (4) cyc();
    chk("count_value", c, count_value);
    do_reset();
    setup(TMWM_MODE_FAST_FF, TMWM_ACT_CLEAR, TMWM_ACT_SET, 8'h40, 8'h40);
    wait_cnt(8'hFF);
    wait_cnt(8'h40);
    chk("wave_out_a", 1'b1, wave_out_a);
    chk("wave_out_b", 1'b0, wave_out_b);
    cyc();
    chk("wave_out_a", 1'b0, wave_out_a);
    chk("wave_out_b", 1'b1, wave_out_b);
    wr_a(8'h90, 8'h40);
    clr_flags();
    wait_cnt(8'hFF);
    cyc();
    chk("count_value", 8'h00, count_value);
    chk("compare_a_value", 8'h90, compare_a_value);
    chk("overflow_flag", 1'b1, overflow_flag);
    measure(n);
    chk("fast period", 16'd256, n[15:0]);
    output_action_a <= TMWM_ACT_TOGGLE;
    repeat (2) cyc();
    a0 = wave_out_a;
    hi_count(300, n);
    chk("toggle without bit2", a0 ? 16'd300 : 16'd0, n[15:0]);
    output_action_b <= TMWM_ACT_TOGGLE;
    wave_mode_sel <= TMWM_MODE_FAST_A;
    measure(n);
    chk("fast top a period", 16'h0091, n[15:0]);
    a0 = wave_out_a;
    b0 = wave_out_b;
    // exactly one period, so exactly one match
    wait_cnt(8'h00);
    chk("wave_out_a", !a0, wave_out_a);
    chk("wave_out_b", b0, wave_out_b);
    do_reset();
    setup(TMWM_MODE_PC_FF, TMWM_ACT_CLEAR, TMWM_ACT_SET, 8'h80, 8'h80);
    cyc();
    chk("wave_out_a", 1'b1, wave_out_a);
    wait_cnt(8'hFE);
    cyc();
    chk("count_value", 8'hFF, count_value);
    cyc();
    chk("count_value", 8'hFE, count_value);
    chk("wave_out_a", 1'b0, wave_out_a);
    chk("wave_out_b", 1'b1, wave_out_b);
    wait_cnt(8'h7F);
    chk("wave_out_a", 1'b1, wave_out_a);
    chk("wave_out_b", 1'b0, wave_out_b);
    clr_flags();
    wait_cnt(8'h00);
    repeat (2) cyc();
    chk("overflow_flag", 1'b1, overflow_flag);
    measure(n);
    chk("pc period", 16'd510, n[15:0]);
    wave_mode_sel <= TMWM_MODE_PC_A;
    measure(n);
    chk("pc top a period", 16'd256, n[15:0]);
    output_action_a <= TMWM_ACT_TOGGLE;
    measure(n);
    a0 = wave_out_a;
    wait_cnt(8'h00);
    chk("wave_out_a", !a0, wave_out_a);
    // extreme compare values: fast then phase correct, bottom then max
    for (int j = 0; j < 4; j++) begin
      do_reset();
      setup(j < 2 ? TMWM_MODE_FAST_FF : TMWM_MODE_PC_FF, TMWM_ACT_CLEAR, TMWM_ACT_CLEAR, j[0] ? 8'hFF : 8'h00, 8'h00);
      repeat (j < 2 ? 270 : 520) cyc();
      hi_count(j < 2 ? 256 : 510, n);
      if (j < 2) chk("fast extreme high ticks", j[0] ? 16'd256 : 16'd1, n[15:0]);
      else chk("pc extreme high ticks", j[0] ? 16'd510 : 16'd0, n[15:0]);
    end
    give_verdict();
  end
  initial begin
    #(50000 * 25);
    num_errors++;
    give_verdict();
  end
endmodule
